// >>> include/obl_pkg.sv
// Constants, register map and state type of the one-time-programmable byte sequencer.
package obl_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CLOCK_GATE = 8'h42;
    localparam logic [7:0] REG_ENABLE = 8'h51;
    localparam logic [7:0] REG_ADDRESS = 8'h52;
    localparam logic [7:0] REG_DATA = 8'h53;
    localparam logic [7:0] REG_COMMAND = 8'h54;
    localparam logic [7:0] REG_STATUS = 8'h58;
    localparam logic [7:0] MEM_FIRST = 8'hdf;
    localparam logic [7:0] MEM_LAST = 8'he8;
    localparam logic [7:0] LOCK_BYTE_ADDR = 8'he8;
    localparam int MEM_BYTES = 10;
    localparam logic [3:0] MEM_COUNT = 4'ha;
    localparam logic [3:0] WALK_LAST = 4'h9;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int CLOCK_GATE_BIT = 0;
    localparam int ENABLE_BIT = 0;
    localparam int CMD_WRITE_BIT = 0;
    localparam int CMD_READ_BIT = 1;
    localparam int CMD_LOCK_BIT = 2;
    localparam int WRITE_OK_BIT = 0;
    localparam int LOCK_OK_BIT = 1;
    localparam int CHECKSUM_OK_BIT = 2;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [2:0] FLAGS_RESET = 3'h0;

    // ------------------------------------------------------------
    // Vendor control requests
    // ------------------------------------------------------------
    localparam logic [7:0] REQ_TYPE_VENDOR_OUT = 8'h40;
    localparam logic [7:0] REQ_TYPE_VENDOR_IN = 8'hc0;
    localparam logic [7:0] REQ_VENDOR_TEST = 8'h01;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 20;
    localparam int PROG_TIME_US = 100;
    localparam int READ_TIME_US = 1;
    localparam int LOCK_TIME_US = 150;
    localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
    localparam int READ_CYCLES = READ_TIME_US * CLK_MHZ;
    localparam int LOCK_CYCLES = LOCK_TIME_US * CLK_MHZ;
    localparam int TIMER_W = 12;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_PROG = 5'b00010,
        ST_VERIFY = 5'b00100,
        ST_READ = 5'b01000,
        ST_LOCK = 5'b10000
    } obl_state_type;
endpackage

// >>> rtl/obl_cell_array.sv
// Fuse array of the programmable bytes with one program port and two read ports.
`timescale 1ns/100ps
module obl_cell_array (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Program port
    input wire logic progStrobe,
    input wire logic [3:0] progIdx,
    input wire logic [7:0] progData,
    // Read ports
    input wire logic [3:0] rdIdxA,
    output logic [7:0] rdDataA,
    input wire logic [3:0] rdIdxB,
    output logic [7:0] rdDataB
);
    import obl_pkg::*;

    logic [7:0] cells [MEM_BYTES];
    logic validA;
    logic validB;

    // Reset models a blank part; a fuse can only go from zero to one.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < MEM_BYTES; i++) begin
                cells[i] <= REG_RESET;
            end
        end else if (progStrobe && (progIdx < MEM_COUNT)) begin
            cells[progIdx] <= cells[progIdx] | progData;
        end
    end

    assign validA = rdIdxA < MEM_COUNT;
    assign validB = rdIdxB < MEM_COUNT;
    assign rdDataA = validA ? cells[rdIdxA] : REG_RESET;
    assign rdDataB = validB ? cells[rdIdxB] : REG_RESET;
endmodule

// >>> rtl/obl_sequencer.sv
// Register file and program, read and lock sequencer of the one-time-programmable bytes.
//
// Behaviour
// - Write bit starts programming, self-clears.
// - Status reports write success flag.
// - Read bit starts read, self-clears.
// - Read byte appears in data register.
// - Status reports lock and checksum flags.
// - Vendor out request writes register byte.
// - Vendor in request returns register byte.
// - Memory bytes mapped at DF to E8.
// - Unprogrammed memory bytes read as zero.
`timescale 1ns/100ps
module obl_sequencer (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Decoded vendor setup stage
    input wire logic setupValid,
    input wire logic [7:0] setupRequestType,
    input wire logic [7:0] setupRequest,
    input wire logic [7:0] setupIndexLow,
    input wire logic [7:0] setupIndexHigh,
    input wire logic [7:0] setupLengthLow,
    input wire logic [7:0] setupLengthHigh,
    // Answer to the request
    output logic respValid,
    output logic respStall,
    output logic [7:0] respData,
    // State seen by the rest of the sensor
    output logic memBusy,
    output logic useMemorySetting
);
    import obl_pkg::*;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    obl_state_type state_r, state_nxt;
    logic [7:0] clockGate_r, clockGate_nxt;
    logic [7:0] enable_r, enable_nxt;
    logic [7:0] address_r, address_nxt;
    logic [7:0] data_r, data_nxt;
    logic [2:0] command_r, command_nxt;
    logic [2:0] flags_r, flags_nxt;
    logic [TIMER_W-1:0] timer_r, timer_nxt;
    logic [3:0] walkIdx_r, walkIdx_nxt;
    logic [7:0] walkSum_r, walkSum_nxt;
    logic [7:0] runSum_r, runSum_nxt;
    logic [7:0] oldByte_r, oldByte_nxt;
    logic lockByteSeen_r, lockByteSeen_nxt;
    logic locked_r, locked_nxt;
    logic progStrobe_r, progStrobe_nxt;
    logic respValid_r, respStall_r;
    logic [7:0] respData_r, respData_nxt;

    // ------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------
    logic isVendor;
    logic lenZero;
    logic lenOne;
    logic regWrite;
    logic regRead;
    logic badRequest;
    logic [7:0] regAddr;
    logic [7:0] wrByte;

    assign isVendor = setupRequest == REQ_VENDOR_TEST;
    assign lenZero = (setupLengthLow == 8'h00) && (setupLengthHigh == 8'h00);
    assign lenOne = (setupLengthLow == 8'h01) && (setupLengthHigh == 8'h00);
    assign regWrite = setupValid && isVendor && (setupRequestType == REQ_TYPE_VENDOR_OUT) && lenZero;
    assign regRead = setupValid && isVendor && (setupRequestType == REQ_TYPE_VENDOR_IN) && lenOne;
    assign badRequest = setupValid && !regWrite && !regRead;
    assign regAddr = setupIndexLow;
    assign wrByte = setupIndexHigh;

    logic idle;
    logic hitClockGate;
    logic hitEnable;
    logic hitAddress;
    logic hitData;
    logic hitCommand;
    logic hitMemory;
    logic hitStatus;
    assign idle = state_r == ST_IDLE;
    assign hitClockGate = regAddr == REG_CLOCK_GATE;
    assign hitEnable = regAddr == REG_ENABLE;
    assign hitAddress = regAddr == REG_ADDRESS;
    assign hitData = regAddr == REG_DATA;
    assign hitCommand = regAddr == REG_COMMAND;
    assign hitMemory = (regAddr >= MEM_FIRST) && (regAddr <= MEM_LAST);
    assign hitStatus = regAddr == REG_STATUS;

    // ------------------------------------------------------------
    // Command acceptance
    // ------------------------------------------------------------
    // A command is taken only with clock gate and enable set, while idle,
    // and only when exactly one command bit is written.
    logic armed;
    logic oneHot;
    logic cmdStart;
    logic startWrite;
    logic startRead;
    logic startLock;
    assign armed = clockGate_r[CLOCK_GATE_BIT] && enable_r[ENABLE_BIT];
    assign oneHot = (wrByte[2:0] == 3'h1) || (wrByte[2:0] == 3'h2) || (wrByte[2:0] == 3'h4);
    assign cmdStart = regWrite && hitCommand && idle && armed && oneHot;
    assign startWrite = cmdStart && wrByte[CMD_WRITE_BIT];
    assign startRead = cmdStart && wrByte[CMD_READ_BIT];
    assign startLock = cmdStart && wrByte[CMD_LOCK_BIT];

    // ------------------------------------------------------------
    // Memory access
    // ------------------------------------------------------------
    logic targetInRange;
    logic [3:0] targetIdx;
    logic [3:0] lockIdx;
    logic [3:0] seqIdx;
    logic [3:0] busIdx;
    logic [7:0] seqByte;
    logic [7:0] busByte;
    logic timerDone;

    assign targetInRange = (address_r >= MEM_FIRST) && (address_r <= MEM_LAST);
    assign targetIdx = targetInRange ? 4'(address_r - MEM_FIRST) : MEM_COUNT;
    assign lockIdx = 4'(LOCK_BYTE_ADDR - MEM_FIRST);
    assign seqIdx = (state_r == ST_LOCK) ? walkIdx_r : targetIdx;
    assign busIdx = hitMemory ? 4'(regAddr - MEM_FIRST) : MEM_COUNT;
    assign timerDone = timer_r == '0;

    obl_cell_array cellArray (
        .clk(clk),
        .rst_n(rst_n),
        .progStrobe(progStrobe_r),
        .progIdx(targetIdx),
        .progData(data_r),
        .rdIdxA(seqIdx),
        .rdDataA(seqByte),
        .rdIdxB(busIdx),
        .rdDataB(busByte)
    );

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    logic writeMatches;
    logic walkEnd;
    assign writeMatches = seqByte == data_r;
    assign walkEnd = walkIdx_r == WALK_LAST;

    always_comb begin
        state_nxt = state_r;
        timer_nxt = timer_r;
        walkIdx_nxt = walkIdx_r;
        walkSum_nxt = walkSum_r;
        runSum_nxt = runSum_r;
        oldByte_nxt = oldByte_r;
        lockByteSeen_nxt = lockByteSeen_r;
        locked_nxt = locked_r;
        progStrobe_nxt = 1'b0;
        flags_nxt = flags_r;
        command_nxt = command_r;
        data_nxt = data_r;
        enable_nxt = enable_r;
        unique case (state_r)
            ST_IDLE: begin
                if (startWrite) begin
                    command_nxt = 3'h1;
                    flags_nxt[WRITE_OK_BIT] = 1'b0;
                    if (targetInRange && !locked_r) begin
                        // A locked part refuses programming; the write then reports failure.
                        oldByte_nxt = seqByte;
                        progStrobe_nxt = 1'b1;
                        timer_nxt = TIMER_W'(PROG_CYCLES - 1);
                        state_nxt = ST_PROG;
                    end else begin
                        timer_nxt = '0;
                        state_nxt = ST_VERIFY;
                    end
                end else if (startRead) begin
                    command_nxt = 3'h2;
                    timer_nxt = TIMER_W'(READ_CYCLES - 1);
                    state_nxt = ST_READ;
                end else if (startLock) begin
                    command_nxt = 3'h4;
                    flags_nxt[LOCK_OK_BIT] = 1'b0;
                    flags_nxt[CHECKSUM_OK_BIT] = 1'b0;
                    walkIdx_nxt = 4'h0;
                    walkSum_nxt = 8'h00;
                    lockByteSeen_nxt = 1'b0;
                    timer_nxt = TIMER_W'(LOCK_CYCLES - 1);
                    state_nxt = ST_LOCK;
                end
            end
            ST_PROG: begin
                timer_nxt = timer_r - 1'b1;
                if (timerDone) begin
                    state_nxt = ST_VERIFY;
                end
            end
            ST_VERIFY: begin
                // Fuses only set bits, so a byte that needs a cleared bit never verifies.
                flags_nxt[WRITE_OK_BIT] = targetInRange && !locked_r && writeMatches;
                if (targetInRange && !locked_r) begin
                    runSum_nxt = runSum_r + (seqByte - oldByte_r);
                end
                command_nxt = 3'h0;
                enable_nxt[ENABLE_BIT] = 1'b0;
                state_nxt = ST_IDLE;
            end
            ST_READ: begin
                timer_nxt = timer_r - 1'b1;
                if (timerDone) begin
                    data_nxt = seqByte;
                    command_nxt = 3'h0;
                    enable_nxt[ENABLE_BIT] = 1'b0;
                    state_nxt = ST_IDLE;
                end
            end
            ST_LOCK: begin
                // The walk re-reads every byte and checks it against the sum kept while programming.
                timer_nxt = timerDone ? timer_r : timer_r - 1'b1;
                if (walkIdx_r < MEM_COUNT) begin
                    walkSum_nxt = walkSum_r + seqByte;
                    lockByteSeen_nxt = lockByteSeen_r || ((walkIdx_r == lockIdx) && (seqByte != 8'h00));
                    walkIdx_nxt = walkEnd ? 4'hf : walkIdx_r + 1'b1;
                end
                if (timerDone && (walkIdx_r == 4'hf)) begin
                    flags_nxt[LOCK_OK_BIT] = lockByteSeen_r;
                    flags_nxt[CHECKSUM_OK_BIT] = walkSum_r == runSum_r;
                    locked_nxt = locked_r || (lockByteSeen_r && (walkSum_r == runSum_r));
                    command_nxt = 3'h0;
                    enable_nxt[ENABLE_BIT] = 1'b0;
                    state_nxt = ST_IDLE;
                end
            end
        endcase
        if (regWrite && hitEnable && idle) begin
            enable_nxt = wrByte;
        end
        if (regWrite && hitData && idle) begin
            data_nxt = wrByte;
        end
    end

    // ------------------------------------------------------------
    // Plain register writes and read answer
    // ------------------------------------------------------------
    assign clockGate_nxt = (regWrite && hitClockGate) ? wrByte : clockGate_r;
    assign address_nxt = (regWrite && hitAddress && idle) ? wrByte : address_r;

    logic [7:0] readMux;
    always_comb begin
        readMux = REG_RESET;
        if (hitClockGate) begin
            readMux = clockGate_r;
        end else if (hitEnable) begin
            readMux = enable_r;
        end else if (hitAddress) begin
            readMux = address_r;
        end else if (hitData) begin
            readMux = data_r;
        end else if (hitCommand) begin
            readMux = {5'h00, command_r};
        end else if (hitStatus) begin
            readMux = {5'h00, flags_r};
        end else if (hitMemory) begin
            readMux = busByte;
        end
    end

    assign respData_nxt = regRead ? readMux : 8'h00;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            clockGate_r <= REG_RESET;
            enable_r <= REG_RESET;
            address_r <= REG_RESET;
            data_r <= REG_RESET;
            command_r <= FLAGS_RESET;
            flags_r <= FLAGS_RESET;
            timer_r <= '0;
            walkIdx_r <= 4'h0;
            walkSum_r <= 8'h00;
            runSum_r <= 8'h00;
            oldByte_r <= 8'h00;
            lockByteSeen_r <= 1'b0;
            locked_r <= 1'b0;
            progStrobe_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            clockGate_r <= clockGate_nxt;
            enable_r <= enable_nxt;
            address_r <= address_nxt;
            data_r <= data_nxt;
            command_r <= command_nxt;
            flags_r <= flags_nxt;
            timer_r <= timer_nxt;
            walkIdx_r <= walkIdx_nxt;
            walkSum_r <= walkSum_nxt;
            runSum_r <= runSum_nxt;
            oldByte_r <= oldByte_nxt;
            lockByteSeen_r <= lockByteSeen_nxt;
            locked_r <= locked_nxt;
            progStrobe_r <= progStrobe_nxt;
        end
    end

    logic busy_r;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            respValid_r <= 1'b0;
            respStall_r <= 1'b0;
            respData_r <= 8'h00;
            busy_r <= 1'b0;
        end else begin
            respValid_r <= regWrite || regRead;
            respStall_r <= badRequest;
            respData_r <= respData_nxt;
            busy_r <= state_nxt != ST_IDLE;
        end
    end
    assign respValid = respValid_r;
    assign respStall = respStall_r;
    assign respData = respData_r;
    assign memBusy = busy_r;
    assign useMemorySetting = locked_r;
endmodule

// >>> sim/obl_seq_monitor.sv
// Port-level assertions of the one-time-programmable byte sequencer.
`timescale 1ns/100ps
module obl_seq_monitor (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Setup stage
    input wire logic setupValid,
    input wire logic [7:0] setupRequestType,
    input wire logic [7:0] setupRequest,
    input wire logic [7:0] setupIndexLow,
    input wire logic [7:0] setupIndexHigh,
    input wire logic [7:0] setupLengthLow,
    input wire logic [7:0] setupLengthHigh,
    // Answer and state
    input wire logic respValid,
    input wire logic respStall,
    input wire logic [7:0] respData,
    input wire logic memBusy,
    input wire logic useMemorySetting
);
    import obl_pkg::*;
    localparam int BUSY_MAX = 3200;
    logic [12:0] busyCnt_r;
    wire goodReq = setupValid && setupRequest == REQ_VENDOR_TEST && setupLengthHigh == 8'h00;
    wire goodWr = goodReq && setupRequestType == REQ_TYPE_VENDOR_OUT && setupLengthLow == 8'h00;
    wire goodRd = goodReq && setupRequestType == REQ_TYPE_VENDOR_IN && setupLengthLow == 8'h01;
    wire cmdWr = goodWr && setupIndexLow == REG_COMMAND;
    // The counter bounds every command; a wedged sequencer shows up here.
    always_ff @(posedge clk) begin
        if (!rst_n || !memBusy) begin
            busyCnt_r <= 13'h0;
        end else begin
            busyCnt_r <= busyCnt_r + 13'h1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    resp_excl_a: assert property (!(respValid && respStall)) else $error("valid and stall together");
    write_ack_a: assert property (goodWr |=> respValid && !respStall) else $error("write not acked");
    read_ack_a: assert property (goodRd |=> respValid && !respStall) else $error("read not acked");
    bad_stall_a: assert property (setupValid && !goodWr && !goodRd |=> respStall && !respValid)
        else $error("bad request not stalled");
    no_spurious_a: assert property (!setupValid |=> !respValid && !respStall) else $error("answer without request");
    data_idle_a: assert property (!respValid |-> respData == 8'h00) else $error("data outside answer");
    busy_cause_a: assert property ($rose(memBusy) |-> $past(cmdWr) || $past(cmdWr, 2))
        else $error("busy without command");
    busy_bound_a: assert property (busyCnt_r < BUSY_MAX) else $error("command never ends");
    lock_use_a: assert property ($rose(useMemorySetting) |-> $past(memBusy) || $past(memBusy, 2))
        else $error("use setting outside lock");
    use_sticky_a: assert property (useMemorySetting |=> useMemorySetting) else $error("use setting dropped");
endmodule
bind obl_sequencer obl_seq_monitor u_mon (.clk(clk), .rst_n(rst_n), .setupValid(setupValid),
    .setupRequestType(setupRequestType), .setupRequest(setupRequest), .setupIndexLow(setupIndexLow),
    .setupIndexHigh(setupIndexHigh), .setupLengthLow(setupLengthLow), .setupLengthHigh(setupLengthHigh),
    .respValid(respValid), .respStall(respStall), .respData(respData), .memBusy(memBusy),
    .useMemorySetting(useMemorySetting));

// >>> sim/obl_host_model.sv
// Host model issuing vendor register requests and the memory access flows.
`timescale 1ns/100ps
module obl_host_model (
    // Clock
    input wire logic clk,
    // Setup stage towards the device
    output logic setupValid,
    output logic [7:0] setupRequestType,
    output logic [7:0] setupRequest,
    output logic [7:0] setupIndexLow,
    output logic [7:0] setupIndexHigh,
    output logic [7:0] setupLengthLow,
    output logic [7:0] setupLengthHigh,
    // Answer from the device
    input wire logic respValid,
    input wire logic respStall,
    input wire logic [7:0] respData
);
    import obl_pkg::*;
    initial begin
        setupValid = 1'b0;
        setupRequestType = 8'h00;
        setupRequest = 8'h00;
        setupIndexLow = 8'h00;
        setupIndexHigh = 8'h00;
        setupLengthLow = 8'h00;
        setupLengthHigh = 8'h00;
    end
    task automatic xfer(input logic [7:0] rt, rq, ix, dt, ln, output logic v, s, output logic [7:0] d);
        @(negedge clk);
        setupValid = 1'b1;
        setupRequestType = rt;
        setupRequest = rq;
        setupIndexLow = ix;
        setupIndexHigh = dt;
        setupLengthLow = ln;
        @(posedge clk);
        @(negedge clk);
        v = respValid;
        s = respStall;
        d = respData;
        setupValid = 1'b0;
        // Index and low length fields are inverted when idle so that a stale value never passes for a live one.
        setupIndexLow = ~ix;
        setupIndexHigh = ~dt;
        setupLengthLow = ~ln;
    endtask
    task automatic wr(input logic [7:0] a, dt);
        logic v, s;
        logic [7:0] d;
        xfer(REQ_TYPE_VENDOR_OUT, REQ_VENDOR_TEST, a, dt, 8'h00, v, s, d);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        logic s;
        xfer(REQ_TYPE_VENDOR_IN, REQ_VENDOR_TEST, a, 8'h00, 8'h01, v, s, d);
    endtask
    // Bounded poll; a stuck command is left for the checker and the watchdog to catch.
    task automatic pollDone();
        logic [7:0] d;
        logic v;
        d = 8'hff;
        for (int i = 0; i < 4000 && d[2:0] !== 3'h0; i++) begin
            rd(REG_COMMAND, d, v);
        end
    endtask
    task automatic nvmWrite(input logic [7:0] a, dt, output logic [7:0] st, output int n);
        logic v;
        n = 0;
        st = 8'h00;
        wr(REG_CLOCK_GATE, 8'h01);
        while (n < 10 && st[WRITE_OK_BIT] !== 1'b1) begin
            wr(REG_ENABLE, 8'h01);
            wr(REG_ADDRESS, a);
            wr(REG_DATA, dt);
            wr(REG_COMMAND, 8'h01);
            pollDone();
            rd(REG_STATUS, st, v);
            n++;
        end
    endtask
    task automatic nvmRead(input logic [7:0] a, output logic [7:0] dt);
        logic v;
        wr(REG_CLOCK_GATE, 8'h01);
        wr(REG_ENABLE, 8'h01);
        wr(REG_ADDRESS, a);
        wr(REG_COMMAND, 8'h02);
        pollDone();
        rd(REG_DATA, dt, v);
    endtask
    task automatic nvmLock(output logic [7:0] st, output int n);
        logic v;
        n = 0;
        st = 8'h00;
        wr(REG_CLOCK_GATE, 8'h01);
        while (n < 10 && st[2:1] !== 2'b11) begin
            wr(REG_ENABLE, 8'h01);
            wr(REG_COMMAND, 8'h04);
            pollDone();
            rd(REG_STATUS, st, v);
            n++;
        end
    endtask
endmodule

// >>> sim/tb_top.sv
// Self-checking testbench of the one-time-programmable byte sequencer.
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin \
    $display("ERROR %s expected %h seen %h", nm, exp, got); fail_count++; end end
module tb_top;
    import obl_pkg::*;
    logic clk, rst_n, setupValid, respValid, respStall, memBusy, useMemorySetting, v, s;
    logic [7:0] rqType, rq, ixLo, ixHi, lnLo, lnHi, respData, d, st;
    int fail_count = 0;
    int num_checks = 0;
    int n;
    logic [7:0] regs [6] = '{REG_CLOCK_GATE, REG_ENABLE, REG_ADDRESS, REG_DATA, REG_COMMAND, REG_STATUS};
    logic [7:0] badT [4] = '{8'h41, 8'h40, 8'h40, 8'hc0};
    logic [7:0] badR [4] = '{8'h01, 8'h02, 8'h01, 8'h01};
    logic [7:0] badL [4] = '{8'h00, 8'h00, 8'h01, 8'h02};
    obl_host_model host (.clk(clk), .setupValid(setupValid), .setupRequestType(rqType), .setupRequest(rq),
        .setupIndexLow(ixLo), .setupIndexHigh(ixHi), .setupLengthLow(lnLo), .setupLengthHigh(lnHi),
        .respValid(respValid), .respStall(respStall), .respData(respData));
    obl_sequencer uut (.clk(clk), .rst_n(rst_n), .setupValid(setupValid), .setupRequestType(rqType),
        .setupRequest(rq), .setupIndexLow(ixLo), .setupIndexHigh(ixHi), .setupLengthLow(lnLo),
        .setupLengthHigh(lnHi), .respValid(respValid), .respStall(respStall), .respData(respData),
        .memBusy(memBusy), .useMemorySetting(useMemorySetting));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clk);
        fail_count++;
        wrap_up();
    end
    initial begin
        rst_n = 1'b0;
        repeat (8) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        `CHK("busy", 1'b0, memBusy)
        `CHK("use", 1'b0, useMemorySetting)
        foreach (regs[i]) begin
            host.rd(regs[i], d, v);
            `CHK("reg reset", 8'h00, d)
        end
        for (int a = 'hdf; a <= 'he8; a++) begin
            host.rd(8'(a), d, v);
            `CHK("blank byte", 8'h00, d)
        end
        host.rd(8'h10, d, v);
        `CHK("unmapped ack", 1'b1, v)
        `CHK("unmapped data", 8'h00, d)
        foreach (badT[i]) begin
            host.xfer(badT[i], badR[i], REG_ADDRESS, 8'h55, badL[i], v, s, d);
            `CHK("stall", 2'b01, {v, s})
        end
        host.wr(REG_ADDRESS, 8'ha5);
        host.rd(REG_ADDRESS, d, v);
        `CHK("address rw", 8'ha5, d)
        host.wr(REG_STATUS, 8'hff);
        host.rd(REG_STATUS, d, v);
        `CHK("status ro", 8'h00, d)
        host.wr(8'hdf, 8'hff);
        host.rd(8'hdf, d, v);
        `CHK("direct fuse write", 8'h00, d)
        host.wr(REG_ENABLE, 8'h01);
        host.wr(REG_COMMAND, 8'h01);
        host.rd(REG_COMMAND, d, v);
        `CHK("cmd without gate", 8'h00, d)
        host.wr(REG_CLOCK_GATE, 8'h01);
        host.wr(REG_COMMAND, 8'h03);
        host.rd(REG_COMMAND, d, v);
        `CHK("two cmd bits", 8'h00, d)
        host.nvmWrite(8'hdf, 8'h3c, st, n);
        `CHK("write ok", 1'b1, st[WRITE_OK_BIT])
        `CHK("write tries", 1, n)
        host.rd(8'hdf, d, v);
        `CHK("fuse byte", 8'h3c, d)
        host.rd(REG_ENABLE, d, v);
        `CHK("enable cleared", 8'h00, d)
        host.nvmWrite(8'he0, 8'h81, st, n);
        host.nvmRead(8'he0, d);
        `CHK("read byte", 8'h81, d)
        host.rd(REG_STATUS, st, v);
        `CHK("read keeps flag", 1'b1, st[WRITE_OK_BIT])
        host.wr(REG_ENABLE, 8'h01);
        host.wr(REG_ADDRESS, 8'he1);
        host.wr(REG_COMMAND, 8'h02);
        host.rd(REG_COMMAND, d, v);
        `CHK("read bit set", 8'h02, d)
        `CHK("busy high", 1'b1, memBusy)
        host.pollDone();
        host.rd(REG_DATA, d, v);
        `CHK("unprogrammed", 8'h00, d)
        host.nvmWrite(8'h10, 8'h55, st, n);
        `CHK("range fail", 1'b0, st[WRITE_OK_BIT])
        `CHK("range tries", 10, n)
        host.nvmWrite(LOCK_BYTE_ADDR, 8'h01, st, n);
        host.nvmLock(st, n);
        `CHK("lock flags", 2'b11, st[2:1])
        `CHK("lock tries", 1, n)
        `CHK("use set", 1'b1, useMemorySetting)
        host.nvmWrite(8'he2, 8'h01, st, n);
        `CHK("locked write", 1'b0, st[WRITE_OK_BIT])
        wrap_up();
    end
endmodule
